// >>> design/irqc_cmd_regs.sv
// irqc_cmd_regs: command and status registers of a vectored interrupt
// controller, with the two active-low lines towards the processor core.
// assumes a same-clock register master, same-clock source levels and
// vector words supplied by the excluded source vector registers.
`timescale 1ns/1ps
`default_nettype none
`include "irqc_cfg.svh"

// How it works
// - a one written to the disable command masks that source; zero leaves it
// - a one written to the clear command clears that pending source
// - a one written to the set command makes that source pending
// - any write to end-of-interrupt ends the current treatment
// - spurious vector register returned by vector reads when nothing is there
// - debug bit 0 enables protection mode; debug register resets to zero
// - debug bit 1 holds both interrupt lines inactive
// - a one written to fast-forcing enable enables that source, for sources 1 to 31 only
// - a one written to fast-forcing disable disables that source
// - fast-forcing status is read-only, bits 1 to 31, bit 0 zero
// - a status one means fast forcing is enabled for that source
// - normal vector read with no current interrupt returns spurious vector
module irqc_cmd_regs #(
  parameter int NSRC = `IRQC_NSRC
) (
  input  wire logic                  sys_clk_in,        // master clock, 25 MHz
  input  wire logic                  rst_in,            // synchronous reset, high
  input  wire irqc_pkg::irqc_bus_req_t bus_req_in,      // register access
  output logic [31:0]                read_data_out,     // read data, cycle after rd
  input  wire logic [NSRC-1:0]       irq_src_in,        // source levels, high
  input  wire logic [31:0]           normal_vec_in,     // vector of current source
  input  wire logic [31:0]           fast_vec_in,       // vector of fast source
  output logic [4:0]                 cur_src_out,       // source to fetch a vector
  output logic                       normal_irq_line_n_out, // normal line, low
  output logic                       fast_irq_line_n_out    // fast line, low
);

  irqc_pkg::irqc_state_t st_reg;
  irqc_pkg::irqc_state_t st_next;

  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] pend_q;
  logic [NSRC-1:0] ff_q;
  logic [NSRC-1:0] mask_set;
  logic [NSRC-1:0] mask_clr;
  logic [NSRC-1:0] pend_set;
  logic [NSRC-1:0] pend_clr;
  logic [NSRC-1:0] ff_set;
  logic [NSRC-1:0] ff_clr;
  logic [NSRC-1:0] active;
  logic [NSRC-1:0] norm_cand;
  logic [NSRC-1:0] ack_vec;
  logic [4:0]      cand_id;
  logic            fast_req;
  logic            normal_irq_line_n_active;
  logic            ack;
  logic            wr_en;
  logic            wr_dis;
  logic            wr_clr;
  logic            wr_set;
  logic            wr_eoi;
  logic            wr_ffe;
  logic            wr_ffd;
  logic            ivr_take;

  assign wr_en  = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_EN_CMD);
  assign wr_dis = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_DIS_CMD);
  assign wr_clr = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_CLR_CMD);
  assign wr_set = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_SET_CMD);
  assign wr_eoi = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_EOI_CMD);
  assign wr_ffe = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_FF_EN);
  assign wr_ffd = bus_req_in.wr && (bus_req_in.addr == `IRQC_OFF_FF_DIS);

  assign mask_set = wr_en  ? bus_req_in.wdata[NSRC-1:0] : '0;
  assign mask_clr = wr_dis ? bus_req_in.wdata[NSRC-1:0] : '0;
  assign pend_set = irq_src_in | (wr_set ? bus_req_in.wdata[NSRC-1:0] : '0);
  assign pend_clr = ack_vec | (wr_clr ? bus_req_in.wdata[NSRC-1:0] : '0);
  // bit 0 is the fast source itself and cannot be forced
  assign ff_set = wr_ffe ? (bus_req_in.wdata[NSRC-1:0] & `IRQC_FF_IMPL) : '0;
  assign ff_clr = wr_ffd ? (bus_req_in.wdata[NSRC-1:0] & `IRQC_FF_IMPL) : '0;

  irqc_w1sc_vec #(.W(NSRC), .RST('0)) u_mask (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .set_in     (mask_set),
    .clr_in     (mask_clr),
    .q_out      (mask_q)
  );

  irqc_w1sc_vec #(.W(NSRC), .RST('0)) u_pend (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .set_in     (pend_set),
    .clr_in     (pend_clr),
    .q_out      (pend_q)
  );

  irqc_w1sc_vec #(.W(NSRC), .RST('0)) u_ff (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .set_in     (ff_set),
    .clr_in     (ff_clr),
    .q_out      (ff_q)
  );

  assign active    = pend_q & mask_q;
  assign fast_req  = active[`IRQC_FAST_SRC] | (|(active & ff_q));
  assign norm_cand = active & ~ff_q & `IRQC_FF_IMPL;
  // one interrupt in service at a time; nesting belongs to the arbiter
  assign normal_irq_line_n_active = (|norm_cand) && !st_reg.in_service;

  // lowest numbered candidate wins; real priority is outside this block
  always_comb begin
    cand_id = 5'h00;
    for (int i = NSRC - 1; i >= 1; i--) begin
      if (norm_cand[i]) begin
        cand_id = 5'(i);
      end
    end
  end

  // in protection mode a debugger read must not acknowledge; a write does
  assign ivr_take = (bus_req_in.addr == `IRQC_OFF_IVR) &&
                    (st_reg.guard ? bus_req_in.wr : bus_req_in.rd);
  assign ack      = ivr_take && normal_irq_line_n_active;
  assign ack_vec  = ack ? (NSRC'(1) << cand_id) : '0;

  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 32'h0000_0000;
    if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        `IRQC_OFF_SPU: begin
          st_next.spu = bus_req_in.wdata;
        end
        `IRQC_OFF_DEBUG: begin
          st_next.guard = bus_req_in.wdata[`IRQC_DBG_GUARD_BIT];
          st_next.gmask = bus_req_in.wdata[`IRQC_DBG_GLOBAL_LINE_MASK_BIT];
        end
        default: begin
        end
      endcase
    end
    if (wr_eoi) begin
      st_next.in_service = 1'b0;
    end
    if (ack) begin
      st_next.in_service = 1'b1;
      st_next.cur_id     = cand_id;
    end
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        `IRQC_OFF_SPU:       st_next.rdata = st_reg.spu;
        `IRQC_OFF_DEBUG:     st_next.rdata = {30'h0, st_reg.gmask, st_reg.guard};
        `IRQC_OFF_FF_STAT:   st_next.rdata = 32'(ff_q) & `IRQC_FF_IMPL;
        `IRQC_OFF_MASK:      st_next.rdata = 32'(mask_q);
        `IRQC_OFF_PEND:      st_next.rdata = 32'(pend_q);
        `IRQC_OFF_IVR:       st_next.rdata = normal_irq_line_n_active ? normal_vec_in : st_reg.spu;
        `IRQC_OFF_FVR:       st_next.rdata = fast_req ? fast_vec_in : st_reg.spu;
        `IRQC_OFF_CORE_STAT: st_next.rdata = {30'h0, ~normal_irq_line_n_out, ~fast_irq_line_n_out};
        `IRQC_OFF_CUR_ID:    st_next.rdata = {27'h0, st_reg.cur_id};
        default:             st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg     <= '0;
      st_reg.spu <= `IRQC_SPU_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign read_data_out         = st_reg.rdata;
  assign cur_src_out           = st_reg.in_service ? st_reg.cur_id : cand_id;
  assign normal_irq_line_n_out = ~(normal_irq_line_n_active && !st_reg.gmask);
  assign fast_irq_line_n_out   = ~(fast_req && !st_reg.gmask);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_disable_cmd: assert property (wr_dis |=> mask_q == ($past(mask_q) & ~$past(bus_req_in.wdata)))
    else $error("disable command did not mask exactly the written bits");
  chk_clear_cmd: assert property (wr_clr |=>
      (pend_q & $past(bus_req_in.wdata) & ~$past(irq_src_in)) == '0)
    else $error("clear command left a pending bit");
  chk_set_cmd: assert property (wr_set |=>
      (pend_q & $past(bus_req_in.wdata)) == $past(bus_req_in.wdata))
    else $error("set command did not make the source pending");
  chk_eoi_release: assert property (wr_eoi |=> !st_reg.in_service)
    else $error("end of interrupt did not release the current one");
  chk_fast_spurious: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_FVR && !fast_req
      |=> read_data_out == $past(st_reg.spu))
    else $error("fast vector read missed the spurious vector");
  chk_guard_noack: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_IVR && st_reg.guard
      |=> st_reg.in_service == $past(st_reg.in_service))
    else $error("protected vector read changed service state");
  chk_gmask_lines: assert property (st_reg.gmask |-> normal_irq_line_n_out && fast_irq_line_n_out)
    else $error("line active under general mask");
  chk_ff_enable: assert property (wr_ffe |=> !ff_q[0] &&
      ((ff_q & $past(bus_req_in.wdata) & `IRQC_FF_IMPL) == ($past(bus_req_in.wdata) & `IRQC_FF_IMPL)))
    else $error("fast forcing enable wrong");
  chk_ff_disable: assert property (wr_ffd |=> (ff_q & $past(bus_req_in.wdata)) == '0)
    else $error("fast forcing disable wrong");
  chk_ffsr_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_FF_STAT
      |=> read_data_out == {$past(ff_q[31:1]), 1'b0})
    else $error("fast forcing status read wrong");
  chk_ivr_spurious: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_IVR && !normal_irq_line_n_active
      |=> read_data_out == $past(st_reg.spu) && !$changed(st_reg.in_service))
    else $error("normal vector read missed the spurious vector");
  chk_wo_read_zero: assert property (bus_req_in.rd && (bus_req_in.addr == `IRQC_OFF_EOI_CMD ||
      bus_req_in.addr == `IRQC_OFF_CLR_CMD || bus_req_in.addr == `IRQC_OFF_FF_EN ||
      bus_req_in.addr == `IRQC_OFF_FF_DIS)
      |=> read_data_out == 32'h0 && $stable(mask_q) && $stable(ff_q))
    else $error("write-only register read not zero");

  // writes of the plain read-write registers must land in the cycle after the strobe
  chk_spu_write: assert property (bus_req_in.wr && bus_req_in.addr == `IRQC_OFF_SPU
      |=> st_reg.spu == $past(bus_req_in.wdata))
    else $error("spurious vector write not stored");
  chk_spu_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_SPU
      |=> read_data_out == $past(st_reg.spu))
    else $error("spurious vector read wrong");
  chk_debug_write: assert property (bus_req_in.wr && bus_req_in.addr == `IRQC_OFF_DEBUG
      |=> st_reg.guard == $past(bus_req_in.wdata[`IRQC_DBG_GUARD_BIT]))
    else $error("protection bit not stored");
  chk_gmask_write: assert property (bus_req_in.wr && bus_req_in.addr == `IRQC_OFF_DEBUG
      |=> st_reg.gmask == $past(bus_req_in.wdata[`IRQC_DBG_GLOBAL_LINE_MASK_BIT]))
    else $error("general mask bit not stored");
  chk_debug_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_DEBUG
      |=> read_data_out == {30'h0, $past(st_reg.gmask), $past(st_reg.guard)})
    else $error("debug control read wrong");
  // a false request right after reset would reach the core before software is ready
  chk_reset_idle: assert property ($fell(rst_in) |-> st_reg.spu == `IRQC_SPU_RST && !st_reg.guard &&
      !st_reg.gmask && !st_reg.in_service && normal_irq_line_n_out && fast_irq_line_n_out)
    else $error("state not idle after reset");
  chk_en_cmd: assert property (wr_en |=>
      (mask_q & $past(bus_req_in.wdata)) == $past(bus_req_in.wdata))
    else $error("enable command did not unmask the written bits");
  // a read-only offset ignores writes, so software cannot corrupt the status
  chk_ffsr_ro: assert property (bus_req_in.wr && bus_req_in.addr == `IRQC_OFF_FF_STAT |=> $stable(ff_q))
    else $error("fast forcing status changed by a write");
  chk_ack_take: assert property (ack |=> st_reg.in_service && st_reg.cur_id == $past(cand_id))
    else $error("acknowledge did not start a treatment");
  chk_ack_pend: assert property (ack |=>
      (pend_q & $past(ack_vec) & ~$past(irq_src_in)) == '0)
    else $error("acknowledged source still pending");
  // only one treatment at a time: the normal line waits for end of interrupt
  chk_single_service: assert property (st_reg.in_service |-> normal_irq_line_n_out)
    else $error("normal line active during a treatment");
  chk_guard_wr_ack: assert property (st_reg.guard && bus_req_in.wr && bus_req_in.addr == `IRQC_OFF_IVR &&
      normal_irq_line_n_active |=> st_reg.in_service)
    else $error("protected acknowledge write ignored");
  chk_ivr_vector: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_IVR && normal_irq_line_n_active
      |=> read_data_out == $past(normal_vec_in))
    else $error("normal vector read missed the current vector");
  chk_fvr_vector: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_FVR && fast_req
      |=> read_data_out == $past(fast_vec_in))
    else $error("fast vector read missed the fast vector");
  chk_fast_free: assert property (!st_reg.gmask && fast_req |-> !fast_irq_line_n_out)
    else $error("fast line held without general mask");
  chk_normal_free: assert property (!st_reg.gmask && normal_irq_line_n_active |-> !normal_irq_line_n_out)
    else $error("normal line held without general mask");
  chk_forced_line: assert property (!st_reg.gmask && (|(active & ff_q)) |-> !fast_irq_line_n_out)
    else $error("forced source did not reach the fast line");
  chk_mask_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_MASK
      |=> read_data_out == 32'($past(mask_q)))
    else $error("mask read wrong");
  chk_pend_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_PEND
      |=> read_data_out == 32'($past(pend_q)))
    else $error("pending read wrong");
  chk_curid_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_CUR_ID
      |=> read_data_out == {27'h0, $past(st_reg.cur_id)})
    else $error("current id read wrong");
  chk_core_stat_read: assert property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_CORE_STAT
      |=> read_data_out == {30'h0, !$past(normal_irq_line_n_out), !$past(fast_irq_line_n_out)})
    else $error("core status read wrong");
  // read data stand for one cycle only, so a stale word is never taken twice
  chk_rdata_idle: assert property (!bus_req_in.rd |=> read_data_out == 32'h0000_0000)
    else $error("read data not zero outside the read answer");
  chk_unmapped_read: assert property (bus_req_in.rd && bus_req_in.addr > `IRQC_OFF_CUR_ID
      |=> read_data_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  cov_ack: cover property (ack ##[1:20] wr_eoi);
  cov_fast: cover property (!fast_irq_line_n_out);
  cov_spurious: cover property (bus_req_in.rd && bus_req_in.addr == `IRQC_OFF_IVR && !normal_irq_line_n_active);
  cov_guard_ack: cover property (st_reg.guard && ack);
  cov_gmask_hold: cover property (st_reg.gmask && (normal_irq_line_n_active || fast_req));

endmodule : irqc_cmd_regs

`default_nettype wire

// >>> design/irqc_cfg.svh
// irqc_cfg.svh: register offsets, field positions and reset values of the
// interrupt controller command registers.
// assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef IRQC_CFG_SVH
`define IRQC_CFG_SVH

`define IRQC_ADDR_W        8
`define IRQC_DATA_W        32
`define IRQC_NSRC          32

`define IRQC_OFF_EN_CMD    8'h00
`define IRQC_OFF_DIS_CMD   8'h04
`define IRQC_OFF_CLR_CMD   8'h08
`define IRQC_OFF_SET_CMD   8'h0c
`define IRQC_OFF_EOI_CMD   8'h10
`define IRQC_OFF_SPU       8'h14
`define IRQC_OFF_DEBUG     8'h18
`define IRQC_OFF_FF_EN     8'h1c
`define IRQC_OFF_FF_DIS    8'h20
`define IRQC_OFF_FF_STAT   8'h24
`define IRQC_OFF_MASK      8'h28
`define IRQC_OFF_PEND      8'h2c
`define IRQC_OFF_IVR       8'h30
`define IRQC_OFF_FVR       8'h34
`define IRQC_OFF_CORE_STAT 8'h38
`define IRQC_OFF_CUR_ID    8'h3c

`define IRQC_DBG_GUARD_BIT 0
`define IRQC_DBG_GLOBAL_LINE_MASK_BIT  1
`define IRQC_FAST_SRC      0
`define IRQC_FF_IMPL       32'hffff_fffe
`define IRQC_SPU_RST       32'h0000_0000
`define IRQC_VEC_RST       32'h0000_0000

`endif

// >>> design/irqc_pkg.sv
// irqc_pkg: types shared by the interrupt controller command register files.
// assumes irqc_cfg.svh is compiled alongside for the constants.
`default_nettype none

package irqc_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } irqc_bus_req_t;

  typedef struct packed {
    logic [31:0] spu;
    logic        guard;
    logic        gmask;
    logic        in_service;
    logic [4:0]  cur_id;
    logic [31:0] rdata;
  } irqc_state_t;

endpackage : irqc_pkg

`default_nettype wire

// >>> design/irqc_w1sc_vec.sv
// irqc_w1sc_vec: a vector of sticky bits with per-bit set and clear.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module irqc_w1sc_vec #(
  parameter int           W   = 32,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         sys_clk_in, // master clock
  input  wire logic         rst_in,     // synchronous reset, high
  input  wire logic [W-1:0] set_in,     // bits to set
  input  wire logic [W-1:0] clr_in,     // bits to clear
  output logic      [W-1:0] q_out       // current bits
);

  typedef struct packed {
    logic [W-1:0] q;
  } irqc_vec_st_t;

  irqc_vec_st_t st_reg;
  irqc_vec_st_t st_next;

  // set wins so an event landing on the clear cycle is kept
  always_comb begin
    st_next   = st_reg;
    st_next.q = (st_reg.q & ~clr_in) | set_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg.q <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.q;

  chk_set_kept: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (set_in != '0) |=> ((q_out & $past(set_in)) == $past(set_in)))
    else $error("set bit not stored");

endmodule : irqc_w1sc_vec

`default_nettype wire

// >>> tb/irqc_core_model.sv
// irqc_core_model: processor core side of the interrupt controller.
// assumes the same master clock; vectors stand in for the excluded vector registers.
`timescale 1ns/1ps
`default_nettype none

module irqc_core_model (
  input  wire logic        sys_clk_in,       // master clock
  input  wire logic        rst_in,           // synchronous reset, high
  input  wire logic        normal_line_n_in, // normal line, low
  input  wire logic        fast_line_n_in,   // fast line, low
  input  wire logic [4:0]  cur_src_in,       // source whose vector is wanted
  output logic      [31:0] normal_vec_out,   // vector of the current source
  output logic      [31:0] fast_vec_out,     // vector of the fast source
  output logic      [15:0] fast_seen_out     // cycles with the fast line active
);
  // the normal vector carries the source number so a wrong index shows in the read data
  assign normal_vec_out = {27'h0000080, cur_src_in};
  assign fast_vec_out   = 32'h0000_2000;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fast_seen_out <= 16'h0000;
    end else if (!fast_line_n_in) begin
      fast_seen_out <= fast_seen_out + 16'h0001;
    end
  end
endmodule : irqc_core_model

`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench of the interrupt controller command registers.
// assumes irqc_pkg and irqc_cfg.svh from design/; core model stands on the line side.
`timescale 1ns/1ps
`default_nettype none
`include "irqc_cfg.svh"

module tb_top;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } irqc_row_t;

  logic                    clk;
  logic                    rst;
  irqc_pkg::irqc_bus_req_t req;
  logic [31:0]             rdata;
  logic [31:0]             src;
  logic [31:0]             nvec;
  logic [31:0]             fvec;
  logic [4:0]              cur;
  logic                    nl_n;
  logic                    fl_n;
  logic [15:0]             fseen;
  int                      fails;
  int                      checks;
  localparam logic [31:0]  SPU = 32'hcafe_0014;

  irqc_row_t rows [31] = '{
    '{1'b1, `IRQC_OFF_SPU, SPU}, '{1'b0, `IRQC_OFF_SPU, SPU},
    '{1'b0, `IRQC_OFF_IVR, SPU}, '{1'b0, `IRQC_OFF_FVR, SPU},
    '{1'b1, `IRQC_OFF_DEBUG, 32'h1}, '{1'b0, `IRQC_OFF_DEBUG, 32'h1}, '{1'b1, `IRQC_OFF_DEBUG, 32'h0},
    '{1'b1, `IRQC_OFF_FF_EN, 32'hffff_ffff}, '{1'b0, `IRQC_OFF_FF_STAT, 32'hffff_fffe},
    '{1'b1, `IRQC_OFF_FF_DIS, 32'h0000_000a}, '{1'b0, `IRQC_OFF_FF_STAT, 32'hffff_fff4},
    '{1'b1, `IRQC_OFF_FF_STAT, 32'h0}, '{1'b0, `IRQC_OFF_FF_STAT, 32'hffff_fff4},
    '{1'b0, `IRQC_OFF_FF_EN, 32'h0}, '{1'b0, `IRQC_OFF_FF_DIS, 32'h0}, '{1'b0, `IRQC_OFF_DIS_CMD, 32'h0},
    '{1'b0, `IRQC_OFF_CLR_CMD, 32'h0}, '{1'b0, `IRQC_OFF_SET_CMD, 32'h0}, '{1'b0, `IRQC_OFF_EOI_CMD, 32'h0},
    '{1'b0, `IRQC_OFF_FF_STAT, 32'hffff_fff4}, '{1'b1, `IRQC_OFF_FF_DIS, 32'hffff_ffff},
    '{1'b1, `IRQC_OFF_EN_CMD, 32'h0000_00ff}, '{1'b1, `IRQC_OFF_DIS_CMD, 32'h0000_0005},
    '{1'b0, `IRQC_OFF_MASK, 32'h0000_00fa}, '{1'b1, `IRQC_OFF_SET_CMD, 32'h0000_0030},
    '{1'b0, `IRQC_OFF_PEND, 32'h0000_0030}, '{1'b1, `IRQC_OFF_CLR_CMD, 32'h0000_0010},
    '{1'b0, `IRQC_OFF_PEND, 32'h0000_0020}, '{1'b1, `IRQC_OFF_CLR_CMD, 32'h0000_0020},
    '{1'b0, `IRQC_OFF_PEND, 32'h0}, '{1'b0, 8'h40, 32'h0}};

  irqc_cmd_regs i_irqc_cmd_regs (.sys_clk_in(clk), .rst_in(rst), .bus_req_in(req), .read_data_out(rdata),
    .irq_src_in(src), .normal_vec_in(nvec), .fast_vec_in(fvec), .cur_src_out(cur),
    .normal_irq_line_n_out(nl_n), .fast_irq_line_n_out(fl_n));

  irqc_core_model i_irqc_core_model (.sys_clk_in(clk), .rst_in(rst), .normal_line_n_in(nl_n),
    .fast_line_n_in(fl_n), .cur_src_in(cur), .normal_vec_out(nvec), .fast_vec_out(fvec),
    .fast_seen_out(fseen));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd

  task automatic lines(input logic n, input logic f);
    #1;
    chk({30'h0, nl_n, fl_n}, {30'h0, n, f});
  endtask : lines

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    src = 32'h0;
    fails = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    // one-cycle source pulse, acknowledge by vector read, end of treatment
    @(posedge clk);
    src <= 32'h0000_0008;
    @(posedge clk);
    src <= 32'h0;
    lines(1'b0, 1'b1);
    rd(`IRQC_OFF_IVR, 32'h0000_1003);
    lines(1'b1, 1'b1);
    rd(`IRQC_OFF_CUR_ID, 32'h0000_0003);
    wr(`IRQC_OFF_SET_CMD, 32'h0000_0010);
    lines(1'b1, 1'b1);
    wr(`IRQC_OFF_EOI_CMD, 32'h5a5a_a5a5);
    lines(1'b0, 1'b1);
    rd(`IRQC_OFF_IVR, 32'h0000_1004);
    wr(`IRQC_OFF_EOI_CMD, 32'h0);
    rd(`IRQC_OFF_IVR, SPU);
    // general mask over both lines, fast forcing moves a source to the fast line
    wr(`IRQC_OFF_SET_CMD, 32'h0000_0020);
    lines(1'b0, 1'b1);
    rd(`IRQC_OFF_CORE_STAT, 32'h0000_0002);
    wr(`IRQC_OFF_DEBUG, 32'h2);
    lines(1'b1, 1'b1);
    wr(`IRQC_OFF_DEBUG, 32'h0);
    wr(`IRQC_OFF_FF_EN, 32'h0000_0020);
    lines(1'b1, 1'b0);
    rd(`IRQC_OFF_CORE_STAT, 32'h0000_0001);
    rd(`IRQC_OFF_FVR, 32'h0000_2000);
    wr(`IRQC_OFF_DEBUG, 32'h2);
    lines(1'b1, 1'b1);
    wr(`IRQC_OFF_DEBUG, 32'h0);
    wr(`IRQC_OFF_FF_DIS, 32'h0000_0020);
    lines(1'b0, 1'b1);
    wr(`IRQC_OFF_CLR_CMD, 32'h0000_0020);
    lines(1'b1, 1'b1);
    chk({31'h0, fseen != 16'h0}, 32'h1);
    // protection mode: vector reads have no side effect
    wr(`IRQC_OFF_DEBUG, 32'h1);
    wr(`IRQC_OFF_SET_CMD, 32'h0000_0008);
    rd(`IRQC_OFF_IVR, 32'h0000_1003);
    lines(1'b0, 1'b1);
    rd(`IRQC_OFF_PEND, 32'h0000_0008);
    wr(`IRQC_OFF_IVR, 32'h0);
    lines(1'b1, 1'b1);
    rd(`IRQC_OFF_CUR_ID, 32'h0000_0003);
    wr(`IRQC_OFF_EOI_CMD, 32'hffff_ffff);
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    lines(1'b1, 1'b1);
    rd(`IRQC_OFF_SPU, 32'h0);
    rd(`IRQC_OFF_DEBUG, 32'h0);
    rd(`IRQC_OFF_MASK, 32'h0);
    rd(`IRQC_OFF_PEND, 32'h0);
    rd(`IRQC_OFF_FF_STAT, 32'h0);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
